// *** hdl/acmp_ctrl.sv ***
// Control and status logic around the on-chip voltage comparator, with an APB slave.
// Assumes the analog core delivers its raw decision synchronous to pclk and that the
// ADC mode and channel bits arrive as plain levels from the ADC block.
//
// Function
// - Result high when plus exceeds minus.
// - Enable bit off forces result low.
// - Minus select one picks bandgap reference.
// - Plus select is inverse of mux enable.
// - Plus from ADC channel mux when zero.
// - Pin drive bit presents result on pin.
// - One 8-bit control register plus 2-bit status and mask registers, all reset zero.
`timescale 1ns/1ps
`default_nettype none

module acmp_ctrl
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [acmp_pkg::APB_AW-1:0] paddr,
    input wire logic [acmp_pkg::APB_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [acmp_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // ADC side levels.
    input wire logic analog_mux_en,
    input wire logic [acmp_pkg::CH_W-1:0] adc_channel_sel,
    // Analog comparator core.
    input wire logic cmp_raw,
    output logic comparator_on,
    output logic minus_ref_select,
    output logic plus_src_sel_n,
    output logic [acmp_pkg::CH_W-1:0] plus_chan_sel,
    // Result port pin.
    output logic result_pin_level,
    output logic result_pin_oe,
    // Interrupt.
    input wire logic irq_ack,
    output logic irq
);
    import acmp_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    logic on_r, mref_r, flag_r, ien_r, pin_r, smp_r, smp_d_r;
    logic [1:0] mode_r;
    logic [STS_W-1:0] sts_r, msk_r;
    logic pready_r, pslverr_r, irq_r, psel_n_r, pin_o_r, pin_oe_r;
    logic [APB_DW-1:0] prdata_r;
    logic [CH_W-1:0] chan_r;

    // ************************************************************
    // APB decode
    // ************************************************************
    // Every access waits one cycle in the access phase so read data comes from a flop.
    wire logic access = psel & penable;
    wire logic pready_nxt = access & ~pready_r;
    wire logic fire = access & pready_r;
    wire logic hit_ccs = (paddr == CCS_ADDR);
    wire logic hit_sts = (paddr == STS_ADDR);
    wire logic hit_msk = (paddr == MSK_ADDR);
    wire logic hit = hit_ccs | hit_sts | hit_msk;
    wire logic wr_ccs = fire & pwrite & hit_ccs & pstrb[0];
    wire logic wr_sts = fire & pwrite & hit_sts & pstrb[0];
    wire logic wr_msk = fire & pwrite & hit_msk & pstrb[0];

    wire logic [7:0] ccs_view = {on_r, mref_r, smp_r, flag_r, ien_r, pin_r, mode_r};
    wire logic [APB_DW-1:0] rd_mux;
    assign rd_mux = hit_ccs ? {24'h000000, ccs_view} :
                    hit_sts ? {{(APB_DW-STS_W){1'b0}}, sts_r} :
                    hit_msk ? {{(APB_DW-STS_W){1'b0}}, msk_r} : 32'h00000000;

    // ************************************************************
    // Comparator result and sampling
    // ************************************************************
    // The core decides plus against minus; a powered-down core reads as low.
    wire logic cmp_result = on_r & cmp_raw;
    wire logic rise = smp_r & ~smp_d_r;
    wire logic fall = ~smp_r & smp_d_r;
    acmp_edge_t mode_e;
    assign mode_e = acmp_edge_t'(mode_r);
    logic edge_hit;
    always_comb
    begin
        case (mode_e)
            EDGE_FALL: edge_hit = fall;
            EDGE_RISE: edge_hit = rise;
            EDGE_BOTH: edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    end

    // ************************************************************
    // Flag, status and interrupt next values
    // ************************************************************
    // A new edge in the clearing cycle wins, so no event is dropped.
    wire logic flag_clr = irq_ack | (wr_ccs & ~pwdata[B_FLAG]);
    wire logic flag_nxt = edge_hit | (flag_r & ~flag_clr);
    wire logic [STS_W-1:0] sts_set = {rise | fall, edge_hit};
    wire logic [STS_W-1:0] sts_w1c = wr_sts ? pwdata[STS_W-1:0] : {STS_W{1'b0}};
    wire logic [STS_W-1:0] sts_nxt = sts_set | (sts_r & ~sts_w1c);
    wire logic irq_nxt = (flag_r & ien_r) | (|(sts_r & msk_r));

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            on_r <= CCS_RST[B_ON];
            mref_r <= CCS_RST[B_MREF];
            smp_r <= CCS_RST[B_RES];
            flag_r <= CCS_RST[B_FLAG];
            ien_r <= CCS_RST[B_IEN];
            pin_r <= CCS_RST[B_PIN];
            mode_r <= CCS_RST[B_MODE_HI:B_MODE_LO];
            smp_d_r <= 1'b0;
        end
        else
        begin
            if (wr_ccs)
            begin
                on_r <= pwdata[B_ON];
                mref_r <= pwdata[B_MREF];
                ien_r <= pwdata[B_IEN];
                pin_r <= pwdata[B_PIN];
                mode_r <= pwdata[B_MODE_HI:B_MODE_LO];
            end
            smp_r <= cmp_result;
            smp_d_r <= smp_r;
            flag_r <= flag_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sts_r <= STS_RST;
            msk_r <= MSK_RST;
            irq_r <= 1'b0;
        end
        else
        begin
            sts_r <= sts_nxt;
            if (wr_msk)
                msk_r <= pwdata[STS_W-1:0];
            irq_r <= irq_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            pready_r <= pready_nxt;
            pslverr_r <= pready_nxt & ~hit;
            if (pready_nxt)
                prdata_r <= pwrite ? 32'h00000000 : rd_mux;
        end
    end

    // The pad and core selects follow pin_r, the gated result and the ADC levels, one flop behind.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            psel_n_r <= 1'b1;
            chan_r <= {CH_W{1'b0}};
            pin_o_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end
        else
        begin
            psel_n_r <= ~analog_mux_en;
            chan_r <= adc_channel_sel;
            pin_o_r <= pin_r & cmp_result;
            pin_oe_r <= pin_r;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign comparator_on = on_r;
    assign minus_ref_select = mref_r;
    assign plus_src_sel_n = psel_n_r;
    assign plus_chan_sel = chan_r;
    assign result_pin_level = pin_o_r;
    assign result_pin_oe = pin_oe_r;
    assign irq = irq_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking acmp_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready stayed high for two cycles");

    ready_wait_a: assert property ((psel && penable && !pready) |=> pready)
        else $error("access phase not answered in one cycle");

    off_low_a: assert property (!comparator_on |=> !smp_r)
        else $error("sampled result high while comparator is off");

    result_sample_a: assert property (smp_r == $past(comparator_on && cmp_raw))
        else $error("sampled result does not follow the gated core decision");

    minus_route_a: assert property (wr_ccs |=> minus_ref_select == $past(pwdata[B_MREF]))
        else $error("minus select did not take the written bit");

    plus_inverse_a: assert property (plus_src_sel_n == !$past(analog_mux_en))
        else $error("plus select is not the inverse of the mux enable");

    chan_route_a: assert property (plus_chan_sel == $past(adc_channel_sel))
        else $error("plus channel select does not follow the ADC channel field");

    pin_drive_a: assert property (!result_pin_oe |-> !result_pin_level)
        else $error("result pin driven high while disabled");

    pin_follow_a: assert property (result_pin_oe |-> result_pin_level == $past(cmp_result))
        else $error("result pin does not show the comparator result");

    rise_flag_a: assert property ((mode_r == EDGE_RISE && $rose(smp_r) && !wr_ccs) |=> flag_r)
        else $error("rising edge did not set the flag");

    rsvd_quiet_a: assert property ((mode_r == EDGE_RSVD && !flag_r) |=> !flag_r)
        else $error("flag set in reserved edge mode");

    result_ro_a: assert property (wr_ccs |=> smp_r == $past(cmp_result))
        else $error("write disturbed the sampled result");

    flag_ack_a: assert property ((irq_ack && !edge_hit) |=> !flag_r)
        else $error("service did not clear the flag");

    irq_gate_a: assert property ((!ien_r && !(|(sts_r & msk_r))) |=> !irq)
        else $error("interrupt raised with flag request disabled and no unmasked status");

    flag_irq_a: assert property ((flag_r && ien_r) |=> irq)
        else $error("enabled flag did not raise the interrupt");

    rise_cover_c: cover property (mode_r == EDGE_RISE ##1 $rose(smp_r) ##1 flag_r);
    both_cover_c: cover property (mode_r == EDGE_BOTH && $fell(smp_r) ##1 flag_r);
    irq_cover_c: cover property (irq ##[1:20] irq_ack);
    err_cover_c: cover property (pslverr);

endmodule // acmp_ctrl

`default_nettype wire

// *** hdl/acmp_pkg.sv ***
// Constants, field layout and types for the comparator control block.
// Assumes a 32-bit APB master and a 25 MHz pclk; no other context is needed.
package acmp_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    localparam int CH_W = 4;

    // ************************************************************
    // Register indices and byte addresses
    // ************************************************************
    // The printed offset is not word aligned, so it is kept as an index.
    localparam logic [APB_AW-1:0] CCS_IDX = 12'h0e9;
    localparam logic [APB_AW-1:0] STS_IDX = 12'h0ea;
    localparam logic [APB_AW-1:0] MSK_IDX = 12'h0eb;
    localparam logic [APB_AW-1:0] CCS_ADDR = {CCS_IDX[APB_AW-3:0], 2'b00};
    localparam logic [APB_AW-1:0] STS_ADDR = {STS_IDX[APB_AW-3:0], 2'b00};
    localparam logic [APB_AW-1:0] MSK_ADDR = {MSK_IDX[APB_AW-3:0], 2'b00};

    // ************************************************************
    // Control/status field positions and reset values
    // ************************************************************
    localparam int B_ON = 7;
    localparam int B_MREF = 6;
    localparam int B_RES = 5;
    localparam int B_FLAG = 4;
    localparam int B_IEN = 3;
    localparam int B_PIN = 2;
    localparam int B_MODE_HI = 1;
    localparam int B_MODE_LO = 0;
    localparam logic [7:0] CCS_RST = 8'h00;

    // ************************************************************
    // Event status and mask layout
    // ************************************************************
    localparam int STS_W = 2;
    localparam int S_EDGE = 0;
    localparam int S_CHG = 1;
    localparam logic [STS_W-1:0] STS_RST = 2'h0;
    localparam logic [STS_W-1:0] MSK_RST = 2'h0;

    // ************************************************************
    // Edge mode encoding
    // ************************************************************
    typedef enum logic [1:0] {
        EDGE_RSVD = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_RISE = 2'b10,
        EDGE_BOTH = 2'b11
    } acmp_edge_t;

endpackage

// *** tb/acmp_core_model.sv ***
// Behavioural model of the analog comparator core and its input pads.
// Assumes pad voltages arrive from the bench in millivolts as plain levels.
`timescale 1ns/1ps
`default_nettype none

module acmp_core_model
(
    // Control from the block.
    input wire logic comparator_on,
    input wire logic minus_ref_select,
    input wire logic plus_src_sel_n,
    // Pad voltages in millivolts.
    input wire logic [11:0] mux_mv,
    input wire logic [11:0] pin_mv,
    input wire logic [11:0] minus_mv,
    input wire logic [11:0] bandgap_mv,
    // Decision.
    output logic cmp_raw
);
    // ************************************************************
    // Input routing and decision
    // ************************************************************
    logic [11:0] plus_v;
    logic [11:0] minus_v;
    assign plus_v = plus_src_sel_n ? pin_mv : mux_mv;
    assign minus_v = minus_ref_select ? bandgap_mv : minus_mv;
    // A powered-down core decides nothing, so its output is held low.
    assign cmp_raw = comparator_on & (plus_v > minus_v);
endmodule // acmp_core_model

`default_nettype wire

// *** tb/test_analog_comparator_control.sv ***
// Self-checking bench for the comparator control block and its APB registers.
// Assumes the core model in acmp_core_model and a 25 MHz pclk.
`timescale 1ns/1ps
`default_nettype none

module test_analog_comparator_control;
    import acmp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, irq_ack, analog_mux_en, e;
    logic pready, pslverr, cmp_raw, comparator_on, minus_ref_select, plus_src_sel_n;
    logic result_pin_level, result_pin_oe, irq;
    logic [11:0] paddr, plus_mv;
    logic [31:0] pwdata, prdata, q, r, seed;
    logic [3:0] pstrb, adc_channel_sel, plus_chan_sel;
    logic [7:0] w;
    logic [1:0] m;
    int miscompares, n_compared;

    acmp_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .analog_mux_en, .adc_channel_sel, .cmp_raw, .comparator_on,
        .minus_ref_select, .plus_src_sel_n, .plus_chan_sel, .result_pin_level, .result_pin_oe,
        .irq_ack, .irq);
    acmp_core_model u_core (.comparator_on, .minus_ref_select, .plus_src_sel_n, .mux_mv(plus_mv),
        .pin_mv(12'h000), .minus_mv(12'h064), .bandgap_mv(12'h7d0), .cmp_raw);

    // ************************************************************
    // Helpers
    // ************************************************************
    always #20 pclk = ~pclk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] ccs_exp(logic [7:0] v, logic res, logic flg);
        return {24'h000000, v[7:6], res, flg, v[3:0]};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; a trailing idle edge keeps back-to-back calls clean.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        if (n >= 50) miscompares++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    task automatic close_out();
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #400000;
        miscompares++;
        close_out();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, irq_ack, analog_mux_en} = '0;
        {paddr, pwdata, adc_channel_sel, plus_mv} = '0;
        pstrb = 4'hf;
        seed = 32'h00000017;
        miscompares = 0;
        n_compared = 0;
        cyc(16);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, CCS_ADDR, 32'h0); chk("ccs reset", 32'h0, q);
        apb(1'b0, STS_ADDR, 32'h0); chk("sts reset", 32'h0, q);
        apb(1'b0, MSK_ADDR, 32'h0); chk("msk reset", 32'h0, q);
        apb(1'b0, 12'h000, 32'h0); chk("unmapped err", 32'h1, {31'h0, e});
        for (int i = 0; i < 8; i++)
        begin
            r = xs();
            w = r[15:8];
            analog_mux_en <= r[0];
            adc_channel_sel <= r[4:1];
            apb(1'b1, CCS_ADDR, {24'h0, w});
            // The pin enable trails the register by one flop, so let it settle first.
            @(posedge pclk);
            chk("plus sel", {31'h0, ~r[0]}, {31'h0, plus_src_sel_n});
            chk("chan sel", {28'h0, r[4:1]}, {28'h0, plus_chan_sel});
            chk("on", {31'h0, w[7]}, {31'h0, comparator_on});
            chk("mref", {31'h0, w[6]}, {31'h0, minus_ref_select});
            chk("pin oe", {31'h0, w[2]}, {31'h0, result_pin_oe});
            apb(1'b0, CCS_ADDR, 32'h0); chk("ccs rw", ccs_exp(w, 1'b0, 1'b0), q);
        end
        analog_mux_en <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            m = k[1:0];
            w = 8'h8c | {6'h0, m};
            apb(1'b1, CCS_ADDR, {24'h0, w});
            plus_mv <= 12'h3e8;
            cyc(5);
            chk("irq rise", {31'h0, m[1]}, {31'h0, irq});
            chk("pin out", 32'h1, {31'h0, result_pin_level});
            apb(1'b0, CCS_ADDR, 32'h0); chk("flag rise", ccs_exp(w, 1'b1, m[1]), q);
            apb(1'b1, CCS_ADDR, {24'h0, w});
            cyc(2);
            chk("irq clr", 32'h0, {31'h0, irq});
            plus_mv <= 12'h000;
            cyc(5);
            chk("irq fall", {31'h0, m[0]}, {31'h0, irq});
            irq_ack <= 1'b1;
            @(posedge pclk);
            irq_ack <= 1'b0;
            cyc(3);
            chk("irq ack", 32'h0, {31'h0, irq});
            apb(1'b0, CCS_ADDR, 32'h0); chk("flag ack", ccs_exp(w, 1'b0, 1'b0), q);
            apb(1'b0, STS_ADDR, 32'h0); chk("sts", {30'h0, 1'b1, m != 2'b00}, q);
            apb(1'b1, MSK_ADDR, 32'h2);
            cyc(2);
            chk("irq mask", 32'h1, {31'h0, irq});
            apb(1'b1, STS_ADDR, 32'h3);
            cyc(2);
            chk("irq w1c", 32'h0, {31'h0, irq});
            apb(1'b1, MSK_ADDR, 32'h0);
        end
        close_out();
    end
endmodule // test_analog_comparator_control

`default_nettype wire
